/* hdl/csm_defs.vh */
// Purpose: Constants for the clock source manager
// Assumes: 40 MHz reference clock
// Notes:   Widths and encodings used by the top-level design file only
`ifndef CSM_DEFS_VH
`define CSM_DEFS_VH

// Number of requesting modules per clock domain
`define CSM_NREQ          8
// High-frequency source select codes
`define CSM_HF_RC         2'h0
`define CSM_HF_XTAL       2'h1
`define CSM_HF_EXT        2'h2
// Low-frequency source select codes
`define CSM_LF_RC         2'h0
`define CSM_LF_XTAL       2'h1
`define CSM_LF_EXT        2'h2
`define CSM_LF_SYNTH      2'h3
// Start-up wait of each oscillator and reference clock period, in ns
`define CSM_HF_XTAL_START_NS  800
`define CSM_HF_RC_START_NS    2500
`define CSM_LF_START_NS       1000
`define CSM_CLK_NS            25
// Reset values
`define CSM_SEL_RST       2'h0

`endif

/* hdl/csm_osc_ctl.v */
// Purpose: Run/idle control and start-up wait for one oscillator
// Assumes: Start and stop come from logic on the same clock
// Notes:   Ready rises after START_CYC cycles of running
`timescale 1ns/1ps
module csm_osc_ctl #(
  parameter [11:0] START_CYC = 12'h001
) (
  input  wire ref_clk_in,
  input  wire rstn_in,
  input  wire need_in,
  output wire run_out,
  output wire ready_out
);

  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_RUN   = 3'h4;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [11:0] cnt_ff;
  reg  [11:0] nxt_cnt;

  // State and start-up counter
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_cnt = 12'h000;
        if (need_in)
          nxt_state = ST_START;
      end
      ST_START:
      begin
        nxt_cnt = cnt_ff + 12'h001;
        if (!need_in)
          nxt_state = ST_IDLE;
        else if (cnt_ff + 12'h001 >= START_CYC)
          nxt_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (!need_in)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 12'h000;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign run_out   = (state_ff != ST_IDLE);
  assign ready_out = (state_ff == ST_RUN);

endmodule

/* hdl/csm_top.v */
// Purpose: Automatic high/low frequency oscillator management
// Assumes: Requests and controls come from logic on ref_clk_in;
//          system_on_in is a pin and is synchronised here
// Notes:   Clock enables gate domain clocks; no clocks in OFF state
// Overview of operation
// (R01) A module request with no running source starts the RC oscillator
// (R02) When requests end, the oscillator the manager started goes idle
// (R03) Software override keeps a chosen oscillator running without requests
// (R04) Clocks are only supplied in the ON state, never when OFF
// (R05) HF clock is 16 MHz; a 32 MHz crystal is divided by two
// (R06) Radio activity forces HF sourcing from the crystal, never RC
// (R07) Synthesized LF clock keeps the HF source running while in use
// (R08) Requests tracked per domain; source runs on request or override
`timescale 1ns/1ps
`include "csm_defs.vh"
module csm_top (
  input  wire                  ref_clk_in,
  input  wire                  rstn_in,
  input  wire                  system_on_in,
  input  wire [`CSM_NREQ-1:0]  hf_req_in,
  input  wire [`CSM_NREQ-1:0]  lf_req_in,
  input  wire                  radio_active_in,
  input  wire                  hf_xtal_keep_in,
  input  wire                  lf_keep_in,
  input  wire [1:0]            lf_src_sel_in,
  input  wire                  xtal_is_32m_in,
  input  wire                  hf_xtal_edge_in,
  output reg                   hf_rc_run_out,
  output reg                   hf_xtal_run_out,
  output reg                   lf_rc_run_out,
  output reg                   lf_xtal_run_out,
  output reg                   hf_clk_en_out,
  output reg                   lf_clk_en_out,
  output reg  [1:0]            hf_src_out,
  output reg                   hf_xtal_div_out,
  output reg                   hf_xtal_tick_out
);

  // Start-up waits rounded up to whole cycles
  localparam integer HFX_WAIT = (`CSM_HF_XTAL_START_NS + `CSM_CLK_NS - 1)
                                / `CSM_CLK_NS;
  localparam integer HFR_WAIT = (`CSM_HF_RC_START_NS + `CSM_CLK_NS - 1)
                                / `CSM_CLK_NS;
  localparam integer LF_WAIT  = (`CSM_LF_START_NS + `CSM_CLK_NS - 1)
                                / `CSM_CLK_NS;
  // Cut on purpose to the controller's 12-bit counter
  localparam [11:0] HFX_CYC = HFX_WAIT[11:0];
  localparam [11:0] HFR_CYC = HFR_WAIT[11:0];
  localparam [11:0] LF_CYC  = LF_WAIT[11:0];

  // Synchroniser and divider flops
  reg        on_meta_ff;
  reg        on_sync_ff;
  reg        edge_meta_ff;
  reg        edge_sync_ff;
  reg        edge_prev_ff;
  reg        div_ff;

  // Request and need terms
  wire       hf_any_req;
  wire       lf_any_req;
  wire       lf_synth;
  wire       hf_need;
  wire       hfx_need;
  wire       hfr_need;
  wire       lfx_need;
  wire       lfr_need;

  // Oscillator controller status
  wire       hfx_run;
  wire       hfx_rdy;
  wire       hfr_run;
  wire       hfr_rdy;
  wire       lfx_run;
  wire       lfx_rdy;
  wire       lfr_run;
  wire       lfr_rdy;

  // Source decode and availability
  wire       lf_use_xtal;
  wire       hf_ok;
  wire       lf_ok;

  // OR-reduce a request vector
  function any_set;
    input [`CSM_NREQ-1:0] v;
    begin
      any_set = |v;
    end
  endfunction

  // Two-flop synchronisers for pin inputs
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      on_meta_ff   <= 1'b0;
      on_sync_ff   <= 1'b0;
      edge_meta_ff <= 1'b0;
      edge_sync_ff <= 1'b0;
      edge_prev_ff <= 1'b0;
    end
    else
    begin
      on_meta_ff   <= system_on_in;
      on_sync_ff   <= on_meta_ff;
      edge_meta_ff <= hf_xtal_edge_in;
      edge_sync_ff <= edge_meta_ff;
      edge_prev_ff <= edge_sync_ff;
    end
  end

  // Per-domain request tracking, gated by system ON
  assign hf_any_req = on_sync_ff & any_set(hf_req_in); // R08 R04
  assign lf_any_req = on_sync_ff & any_set(lf_req_in); // R08 R04
  assign lf_synth   = (lf_src_sel_in == `CSM_LF_SYNTH);
  assign lf_use_xtal = (lf_src_sel_in == `CSM_LF_XTAL) |
                       (lf_src_sel_in == `CSM_LF_EXT);

  // HF needed by modules, radio, or synthesized LF
  assign hf_need  = hf_any_req | (on_sync_ff & radio_active_in)
                  | (lf_any_req & lf_synth)             // R07
                  | (on_sync_ff & lf_keep_in & lf_synth); // R07
  // Crystal runs on override or radio; else RC fills in
  assign hfx_need = on_sync_ff & (hf_xtal_keep_in | radio_active_in); // R03 R06
  assign hfr_need = hf_need & ~hfx_need; // R01 R02 R06
  // LF source chosen by selection; RC is the automatic default
  assign lfx_need = on_sync_ff & lf_use_xtal
                  & (lf_any_req | lf_keep_in); // R03 R08
  assign lfr_need = on_sync_ff & (lf_src_sel_in == `CSM_LF_RC)
                  & (lf_any_req | lf_keep_in); // R01 R02 R08

  // HF crystal: started by override or radio only
  csm_osc_ctl #(.START_CYC(HFX_CYC)) u_hfx (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .need_in    (hfx_need),
    .run_out    (hfx_run),
    .ready_out  (hfx_rdy)
  );

  // HF RC oscillator: automatic source for module requests
  csm_osc_ctl #(.START_CYC(HFR_CYC)) u_hfr (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .need_in    (hfr_need),
    .run_out    (hfr_run),
    .ready_out  (hfr_rdy)
  );

  // LF crystal or external source, by selection
  csm_osc_ctl #(.START_CYC(LF_CYC)) u_lfx (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .need_in    (lfx_need),
    .run_out    (lfx_run),
    .ready_out  (lfx_rdy)
  );

  // LF RC oscillator, the automatic LF default
  csm_osc_ctl #(.START_CYC(LF_CYC)) u_lfr (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .need_in    (lfr_need),
    .run_out    (lfr_run),
    .ready_out  (lfr_rdy)
  );

  // Clock availability per domain
  assign hf_ok = hfx_rdy | hfr_rdy;
  assign lf_ok = lf_synth ? hf_ok : (lfx_rdy | lfr_rdy); // R07

  // Crystal divider: 32 MHz crystal halved to give 16 MHz
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      div_ff           <= 1'b0;
      hf_xtal_tick_out <= 1'b0;
    end
    else
    begin
      if (!hfx_rdy)
        div_ff <= 1'b0;
      else if (edge_sync_ff & ~edge_prev_ff)
        div_ff <= ~div_ff;
      // One tick per 16 MHz period
      hf_xtal_tick_out <= hfx_rdy & edge_sync_ff & ~edge_prev_ff
                        & (~xtal_is_32m_in | div_ff); // R05
    end
  end

  // Registered outputs
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hf_rc_run_out   <= 1'b0;
      hf_xtal_run_out <= 1'b0;
      lf_rc_run_out   <= 1'b0;
      lf_xtal_run_out <= 1'b0;
      hf_clk_en_out   <= 1'b0;
      lf_clk_en_out   <= 1'b0;
      hf_src_out      <= `CSM_SEL_RST;
      hf_xtal_div_out <= 1'b0;
    end
    else
    begin
      hf_rc_run_out   <= hfr_run;
      hf_xtal_run_out <= hfx_run;
      lf_rc_run_out   <= lfr_run;
      lf_xtal_run_out <= lfx_run;
      hf_clk_en_out   <= on_sync_ff & hf_ok
                       & (hf_need | hfx_need); // R04
      lf_clk_en_out   <= on_sync_ff & lf_ok
                       & (lf_any_req | lf_keep_in); // R04
      hf_src_out      <= hfx_rdy ? `CSM_HF_XTAL : `CSM_HF_RC; // R06
      hf_xtal_div_out <= xtal_is_32m_in; // R05
    end
  end

endmodule

/* testbench/csm_req_model.sv */
// Purpose: Peripheral modules asking for clocks
// Assumes: Module enables come from the bench
// Notes:   Requests follow enables one edge late
`timescale 1ns/1ps
module csm_req_model (
  input  wire       clk_in,
  input  wire       rstn_in,
  input  wire [7:0] hf_en_in,
  input  wire [7:0] lf_en_in,
  output reg  [7:0] hf_req_out,
  output reg  [7:0] lf_req_out,
  output reg        xtal_edge_out
);
  // Requests and crystal edge marks
  always @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      hf_req_out    <= 8'h00;
      lf_req_out    <= 8'h00;
      xtal_edge_out <= 1'b0;
    end
    else
    begin
      hf_req_out    <= hf_en_in;
      lf_req_out    <= lf_en_in;
      xtal_edge_out <= ~xtal_edge_out;
    end
endmodule

/* testbench/csm_top_props.sv */
// Purpose: Port checks for the clock manager
// Assumes: Bound to csm_top
// Notes:   Windows cover the ON synchroniser
`timescale 1ns/1ps
module csm_top_chk (
  input wire       ref_clk_in,
  input wire       rstn_in,
  input wire       system_on_in,
  input wire [7:0] hf_req_in,
  input wire [7:0] lf_req_in,
  input wire       radio_active_in,
  input wire       hf_xtal_keep_in,
  input wire [1:0] lf_src_sel_in,
  input wire       xtal_is_32m_in,
  input wire       hf_rc_run_out,
  input wire       hf_xtal_run_out,
  input wire       lf_rc_run_out,
  input wire       hf_clk_en_out,
  input wire       lf_clk_en_out,
  input wire       hf_xtal_div_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // No radio and no crystal override
  wire hf_free = !radio_active_in && !hf_xtal_keep_in;
  wire hf_any  = hf_rc_run_out || hf_xtal_run_out;
  rc_start_a: assert property (
    (system_on_in && |hf_req_in && hf_free)[*5] |-> hf_any)
    else $error("HF source not started");
  hf_idle_a: assert property (
    (hf_req_in == 8'h00 && hf_free && lf_src_sel_in != 2'h3)[*3]
    |-> !hf_any) else $error("HF source left running");
  xtal_keep_a: assert property (
    (system_on_in && hf_xtal_keep_in)[*5] |-> hf_xtal_run_out)
    else $error("crystal override ignored");
  off_state_a: assert property (
    (!system_on_in)[*5] |-> !hf_clk_en_out && !lf_clk_en_out)
    else $error("clock while OFF");
  div_off_a: assert property (
    (!xtal_is_32m_in)[*3] |-> !hf_xtal_div_out)
    else $error("divide with 16 MHz crystal");
  radio_xtal_a: assert property (
    radio_active_in[*3] |-> !hf_rc_run_out)
    else $error("RC runs with radio");
  synth_hold_a: assert property (
    (system_on_in && |lf_req_in && lf_src_sel_in == 2'h3)[*5] |-> hf_any)
    else $error("synth LF without HF");
  lf_rc_a: assert property (
    (system_on_in && |lf_req_in && lf_src_sel_in == 2'h0)[*5]
    |-> lf_rc_run_out) else $error("LF RC not run");
endmodule
bind csm_top csm_top_chk u_csm_top_chk (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .system_on_in(system_on_in),
  .hf_req_in(hf_req_in), .lf_req_in(lf_req_in),
  .radio_active_in(radio_active_in), .hf_xtal_keep_in(hf_xtal_keep_in),
  .lf_src_sel_in(lf_src_sel_in), .xtal_is_32m_in(xtal_is_32m_in),
  .hf_rc_run_out(hf_rc_run_out), .hf_xtal_run_out(hf_xtal_run_out),
  .lf_rc_run_out(lf_rc_run_out), .hf_clk_en_out(hf_clk_en_out),
  .lf_clk_en_out(lf_clk_en_out), .hf_xtal_div_out(hf_xtal_div_out));

/* testbench/csm_top_tb_top.sv */
// Purpose: Self-checking bench for the clock manager
// Assumes: 40 MHz clock, requests via module model
// Notes:   Check windows follow hand-over latencies
`timescale 1ns/1ps
module csm_top_tb_top;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        son = 1'b0;
  reg        radio = 1'b0;
  reg        keep = 1'b0;
  reg        lkeep = 1'b0;
  reg        x32 = 1'b0;
  reg  [1:0] sel = 2'h0;
  reg  [7:0] hen = 8'h00;
  reg  [7:0] len = 8'h00;
  wire [7:0] hreq, lreq;
  wire       edg, hrc, hx, lrc, hck, lck, div, lxr, tck;
  wire [1:0] src;
  int        err_count = 0;
  int        total_checks = 0;
  int        cyc = 0;
  always #12.5 clk = ~clk;
  csm_req_model u_csm_req_model (.clk_in(clk), .rstn_in(rstn),
    .hf_en_in(hen), .lf_en_in(len), .hf_req_out(hreq),
    .lf_req_out(lreq), .xtal_edge_out(edg));
  csm_top u_csm_top (.ref_clk_in(clk), .rstn_in(rstn),
    .system_on_in(son), .hf_req_in(hreq), .lf_req_in(lreq),
    .radio_active_in(radio), .hf_xtal_keep_in(keep),
    .lf_keep_in(lkeep), .lf_src_sel_in(sel), .xtal_is_32m_in(x32),
    .hf_xtal_edge_in(edg), .hf_rc_run_out(hrc), .hf_xtal_run_out(hx),
    .lf_rc_run_out(lrc), .lf_xtal_run_out(lxr), .hf_clk_en_out(hck),
    .lf_clk_en_out(lck), .hf_src_out(src), .hf_xtal_div_out(div),
    .hf_xtal_tick_out(tck));
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task t_rc;
    hen = 8'h80;
    wt(6);
    chk("hf_rc", 1'b1, hrc);
    wt(89);
    chk("hf_early", 1'b0, hck);
    wt(13);
    chk("hf_clk", 1'b1, hck);
    chk("hf_src", 2'h0, src);
    hen = 8'h00;
    wt(6);
    chk("rc_idle", 1'b0, hrc);
    chk("clk_off", 1'b0, hck);
    $display("t_rc done");
  endtask
  task t_keep;
    logic [7:0] n;
    keep = 1'b1;
    x32 = 1'b1;
    lkeep = 1'b1;
    wt(45);
    chk("xtal", 1'b1, hx);
    chk("div", 1'b1, div);
    chk("lf_kept", 1'b1, lrc);
    // Crystal edge every 2 cycles, halved: one tick per 4
    n = 8'h00;
    repeat (16)
    begin
      wt(1);
      n = n + {7'h00, tck};
    end
    chk("tick_32m", 8'h04, n);
    x32 = 1'b0;
    wt(2);
    chk("div_off", 1'b0, div);
    // Undivided: one tick per crystal edge
    n = 8'h00;
    repeat (16)
    begin
      wt(1);
      n = n + {7'h00, tck};
    end
    chk("tick_16m", 8'h08, n);
    keep = 1'b0;
    lkeep = 1'b0;
    wt(6);
    chk("xtal_idle", 1'b0, hx);
    chk("lf_idle", 1'b0, lrc);
    $display("t_keep done");
  endtask
  task t_radio;
    radio = 1'b1;
    hen = 8'h01;
    wt(45);
    chk("no_rc", 1'b0, hrc);
    chk("x_clk", 1'b1, hck);
    chk("x_src", 2'h1, src);
    radio = 1'b0;
    hen = 8'h00;
    wt(6);
    $display("t_radio done");
  endtask
  task t_synth;
    sel = 2'h3;
    len = 8'h10;
    wt(150);
    chk("lf_clk", 1'b1, lck);
    chk("hf_held", 1'b1, hrc | hx);
    len = 8'h00;
    wt(6);
    sel = 2'h0;
    $display("t_synth done");
  endtask
  task t_off;
    son = 1'b0;
    wt(4);
    hen = 8'hff;
    len = 8'hff;
    wt(8);
    chk("off_rc", 1'b0, hrc);
    chk("off_lf", 1'b0, lrc);
    chk("off_hck", 1'b0, hck);
    chk("off_lck", 1'b0, lck);
    son = 1'b1;
    wt(8);
    chk("on_rc", 1'b1, hrc);
    chk("on_lf", 1'b1, lrc);
    hen = 8'h00;
    len = 8'h00;
    wt(6);
    $display("t_off done");
  endtask
  task t_lfx;
    sel = 2'h1;
    len = 8'h01;
    wt(30);
    chk("lx_run", 1'b1, lxr);
    chk("lx_no_rc", 1'b0, lrc);
    chk("lx_early", 1'b0, lck);
    wt(20);
    chk("lx_clk", 1'b1, lck);
    sel = 2'h2;
    wt(6);
    chk("ext_run", 1'b1, lxr);
    chk("ext_clk", 1'b1, lck);
    len = 8'h00;
    wt(6);
    chk("lx_idle", 1'b0, lxr);
    chk("lx_off", 1'b0, lck);
    sel = 2'h0;
    $display("t_lfx done");
  endtask
  task t_reset;
    hen = 8'h01;
    x32 = 1'b1;
    wt(6);
    chk("pre_rc", 1'b1, hrc);
    chk("pre_div", 1'b1, div);
    rstn = 1'b0;
    wt(1);
    chk("rst_rc", 1'b0, hrc);
    chk("rst_hck", 1'b0, hck);
    chk("rst_div", 1'b0, div);
    rstn = 1'b1;
    wt(8);
    chk("rst_again", 1'b1, hrc);
    hen = 8'h00;
    x32 = 1'b0;
    wt(6);
    chk("rst_idle", 1'b0, hrc);
    $display("t_reset done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      wrap_up;
    end
  end
  // Main sequence
  initial
  begin
    wt(2);
    rstn = 1'b1;
    son = 1'b1;
    wt(4);
    t_rc;
    t_keep;
    t_radio;
    t_lfx;
    t_synth;
    t_off;
    t_reset;
    wrap_up;
  end
endmodule
